/* File: src/bridge_misc_control_status.sv */
// miscellaneous control, reset control and eeprom register port
// assumes a same-clock serial eeprom engine, pins synchronised here
`timescale 1ns/10ps
`default_nettype none

module bridge_misc_control_status (
   input wire logic clk,
   input wire logic rst_n,
   // pins from outside the clock domain
   input wire logic pci_rst_n,
   input wire logic local_reset_in_n,
   input wire logic burst_progress_strap,
   input wire logic size_strap_bit,
   input wire logic ee_sda_in,
   input wire logic id_enable_strap,
   // register port, one access per strobe
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   // serial eeprom engine, same clock
   input wire logic ee_loading,
   input wire logic ee_done,
   input wire logic [7:0] ee_rdata,
   output logic ee_start,
   output logic ee_read,
   output logic [7:0] ee_addr,
   output logic [7:0] ee_wdata,
   // local bus control
   output logic local_reset_out_n,
   output logic [7:0] prefetch_bytes,
   output logic [1:0] strap_bus_modes,
   output logic [1:0] master_type,
   output logic slave_family,
   output logic sync_grant_sel,
   output logic sync_busy_sel,
   // byte order per data channel
   input wire logic target_order_invert,
   input wire logic dma_order_invert,
   output logic slave_swap,
   output logic target_swap,
   output logic dma_swap,
   output logic target_abort_to_error
);

   localparam int NSYNC = 6;
   // reset values of the synchronisers: reset pins idle high
   localparam logic [NSYNC-1:0] SYNC_RST = 6'h03;

   // decode of the mode field into a master type
   function automatic bridge_misc_pkg::master_type_t decode_master(
         input logic [1:0] m);
      bridge_misc_pkg::master_type_t t;
      t = bridge_misc_pkg::MASTER_FIRST;
      if (m == 2'h2) begin
         t = bridge_misc_pkg::MASTER_SECOND;
      end else if (m == 2'h3) begin
         t = bridge_misc_pkg::MASTER_THIRD;
      end
      return t;
   endfunction

   // two-stage synchronisers for every pin
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   assign pin_raw = {id_enable_strap, ee_sda_in, size_strap_bit,
                     burst_progress_strap, local_reset_in_n, pci_rst_n};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         // first stage feeds only the second
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q[g] <= SYNC_RST[g];
               sync_q[g] <= SYNC_RST[g];
            end else begin
               meta_q[g] <= pin_raw[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // synchronised pin levels
   wire pci_rst_act = !sync_q[0];
   wire lrst_in_act = !sync_q[1];
   wire burst_s = sync_q[2];
   wire size_s = sync_q[3];
   wire sda_s = sync_q[4];
   wire id_s = sync_q[5];

   // register state
   logic soft_rst_q, soft_rst_d;
   logic pci_hold_q, pci_hold_d; // output held through pci reset
   logic lrst_out_q;
   logic ma_off_q;
   logic sync_grant_q, sync_busy_q;
   logic byte_order_q;
   logic [1:0] fifo_q; // two mode bits that must stay zero
   logic [5:0] prefetch_q;
   logic [1:0] modes_q;
   logic [1:0] cap_cnt_q;
   logic strap_done_q;
   logic [31:0] misc2_q;
   logic [7:0] ee_addr_q, ee_data_q;
   logic ee_read_q;
   logic ee_busy_q;
   logic ee_start_q;
   logic no_ee_q;
   logic [31:0] rdata_q;
   logic ack_q;

   // address decode
   wire hit_misc = reg_addr == bridge_misc_pkg::MISC_CONTROL_STATUS_OFS;
   wire hit_ee = reg_addr == bridge_misc_pkg::EE_CS_OFS;
   wire hit_misc2 = reg_addr == bridge_misc_pkg::MISC2_OFS;
   wire wr_misc = reg_wr && hit_misc;
   wire wr_misc2 = reg_wr && hit_misc2;

   // eeprom access gating
   wire ee_enable = misc2_q[bridge_misc_pkg::EE_ENABLE_BIT];
   wire ee_usable = !no_ee_q || ee_enable;
   wire ee_active = ee_busy_q || ee_loading;
   // writes to a busy register are dropped silently
   wire ee_accept = reg_wr && hit_ee && !ee_active && ee_usable &&
                    !pci_rst_act;

   // soft reset control: the reset inputs beat a software write
   always_comb begin
      soft_rst_d = soft_rst_q;
      pci_hold_d = pci_hold_q;
      if (wr_misc) begin
         soft_rst_d = reg_wdata[bridge_misc_pkg::SOFT_RST_BIT];
      end
      if (pci_rst_act) begin
         // keep the output asserted while pci reset lasts
         pci_hold_d = soft_rst_q || pci_hold_q;
         soft_rst_d = 1'b0;
      end else begin
         pci_hold_d = 1'b0;
      end
      if (lrst_in_act) begin
         // the input is not fed from the output outside
         soft_rst_d = 1'b0;
         pci_hold_d = 1'b0;
      end
   end

   // soft reset state and the registered reset output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst_q <= 1'b0;
         pci_hold_q <= 1'b0;
         lrst_out_q <= 1'b0;
      end else begin
         soft_rst_q <= soft_rst_d;
         pci_hold_q <= pci_hold_d;
         lrst_out_q <= soft_rst_d || pci_hold_d;
      end
   end

   // strap capture a fixed delay after general reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
         modes_q <= 2'h0;
      end else if (!strap_done_q) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
         if (cap_cnt_q == bridge_misc_pkg::STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            modes_q <= {burst_s, size_s};
         end
      end
   end

   // the sync selects take their reset value from the mode straps
   wire [1:0] cap_modes = {burst_s, size_s};
   wire cap_sync = decode_master(cap_modes) !=
                   bridge_misc_pkg::MASTER_FIRST;

   // misc control register fields
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ma_off_q <= 1'b0;
         sync_grant_q <= 1'b0;
         sync_busy_q <= 1'b0;
         byte_order_q <= 1'b0;
         fifo_q <= 2'h0;
         prefetch_q <= bridge_misc_pkg::PREFETCH_RST;
      end else if (!strap_done_q) begin
         // reset values are taken from the straps when capture ends
         if (cap_cnt_q == bridge_misc_pkg::STRAP_WAIT) begin
            sync_grant_q <= cap_sync;
            sync_busy_q <= cap_sync;
         end
      end else if (wr_misc) begin
         ma_off_q <= reg_wdata[bridge_misc_pkg::MA_OFF_BIT];
         sync_grant_q <= reg_wdata[bridge_misc_pkg::SYNC_GRANT_BIT];
         sync_busy_q <= reg_wdata[bridge_misc_pkg::SYNC_BUSY_BIT];
         byte_order_q <= reg_wdata[bridge_misc_pkg::BYTE_ORDER_BIT];
         fifo_q <= reg_wdata[bridge_misc_pkg::FIFO_LSB +: 2];
         prefetch_q <= reg_wdata[bridge_misc_pkg::PREFETCH_LSB +: 6];
      end
   end

   // second control register, stored whole
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         misc2_q <= bridge_misc_pkg::MISC2_RST;
      end else if (wr_misc2) begin
         misc2_q <= reg_wdata;
      end
   end

   // eeprom presence is sampled for as long as pci reset lasts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         no_ee_q <= 1'b0;
      end else if (pci_rst_act) begin
         no_ee_q <= !sda_s && !id_s;
      end
   end

   // eeprom register: fields cleared by pci reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ee_addr_q <= 8'h00;
         ee_data_q <= 8'h00;
         ee_read_q <= 1'b0;
         ee_busy_q <= 1'b0;
         ee_start_q <= 1'b0;
      end else if (pci_rst_act) begin
         ee_addr_q <= 8'h00;
         ee_data_q <= 8'h00;
         ee_read_q <= 1'b0;
         ee_busy_q <= 1'b0;
         ee_start_q <= 1'b0;
      end else begin
         ee_start_q <= ee_accept;
         if (ee_accept) begin
            ee_addr_q <= reg_wdata[bridge_misc_pkg::EE_ADDR_LSB +: 8];
            ee_data_q <= reg_wdata[bridge_misc_pkg::EE_DATA_LSB +: 8];
            ee_read_q <= reg_wdata[bridge_misc_pkg::EE_READ_BIT];
            ee_busy_q <= 1'b1;
         end else if (ee_busy_q && ee_done) begin
            ee_busy_q <= 1'b0;
            if (ee_read_q) begin
               ee_data_q <= ee_rdata;
            end
         end
      end
   end

   // read images of the three registers
   logic [31:0] misc_img, ee_img, rd_mux;
   always_comb begin
      misc_img = 32'h0000_0000;
      misc_img[bridge_misc_pkg::SOFT_RST_BIT] = soft_rst_q;
      misc_img[bridge_misc_pkg::MA_OFF_BIT] = ma_off_q;
      misc_img[bridge_misc_pkg::SYNC_GRANT_BIT] = sync_grant_q;
      misc_img[bridge_misc_pkg::SYNC_BUSY_BIT] = sync_busy_q;
      misc_img[bridge_misc_pkg::BYTE_ORDER_BIT] = byte_order_q;
      misc_img[bridge_misc_pkg::MODES_LSB +: 2] = modes_q;
      misc_img[bridge_misc_pkg::FIFO_LSB +: 2] = fifo_q;
      misc_img[bridge_misc_pkg::PREFETCH_LSB +: 6] = prefetch_q;
      ee_img = 32'h0000_0000;
      if (ee_usable) begin
         ee_img[bridge_misc_pkg::EE_ADDR_LSB +: 8] = ee_addr_q;
         ee_img[bridge_misc_pkg::EE_DATA_LSB +: 8] = ee_data_q;
         ee_img[bridge_misc_pkg::EE_ACT_BIT] = ee_active;
         ee_img[bridge_misc_pkg::EE_READ_BIT] = ee_read_q;
      end
      // unmapped offsets read zero
      rd_mux = 32'h0000_0000;
      if (hit_misc) begin
         rd_mux = misc_img;
      end else if (hit_ee) begin
         rd_mux = ee_img;
      end else if (hit_misc2) begin
         rd_mux = misc2_q;
      end
   end

   // answer: every access acks one cycle later, ignored or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
      end else begin
         ack_q <= reg_wr || reg_rd;
         if (reg_rd) begin
            // bit order kept as stored whatever the byte order
            rdata_q <= rd_mux;
         end
      end
   end

   // registered local bus controls
   logic [7:0] pf_bytes_q;
   logic [1:0] mtype_q;
   logic sfam_q, slv_sw_q, tgt_sw_q, dma_sw_q, ta_map_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pf_bytes_q <= 8'h04;
         mtype_q <= 2'h0;
         sfam_q <= 1'b0;
         slv_sw_q <= 1'b0;
         tgt_sw_q <= 1'b0;
         dma_sw_q <= 1'b0;
         ta_map_q <= 1'b1;
      end else begin
         pf_bytes_q <= {prefetch_q, 2'h0};
         mtype_q <= decode_master(modes_q);
         sfam_q <= modes_q[0];
         slv_sw_q <= byte_order_q;
         tgt_sw_q <= byte_order_q ^ target_order_invert;
         dma_sw_q <= byte_order_q ^ dma_order_invert;
         // error mapping of target aborts
         ta_map_q <= !ma_off_q || misc2_q[bridge_misc_pkg::TA_ON_BIT];
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;
   assign ee_start = ee_start_q;
   assign ee_read = ee_read_q;
   assign ee_addr = ee_addr_q;
   assign ee_wdata = ee_data_q;
   assign local_reset_out_n = !lrst_out_q;
   assign prefetch_bytes = pf_bytes_q;
   assign strap_bus_modes = modes_q;
   assign master_type = mtype_q;
   assign slave_family = sfam_q;
   assign sync_grant_sel = sync_grant_q;
   assign sync_busy_sel = sync_busy_q;
   assign slave_swap = slv_sw_q;
   assign target_swap = tgt_sw_q;
   assign dma_swap = dma_sw_q;
   assign target_abort_to_error = ta_map_q;

endmodule

`default_nettype wire

/* File: src/bridge_misc_pkg.sv */
// constants shared by the miscellaneous control and eeprom access block
// assumes a single 250 MHz clock and word-wide register accesses
package bridge_misc_pkg;
   // register offsets, byte addresses
   localparam logic [11:0] MISC_CONTROL_STATUS_OFS = 12'h800;
   localparam logic [11:0] EE_CS_OFS = 12'h804;
   localparam logic [11:0] MISC2_OFS = 12'h808;
   // misc control and status fields
   localparam int SOFT_RST_BIT = 31;
   localparam int MA_OFF_BIT = 20;
   localparam int SYNC_GRANT_BIT = 19;
   localparam int SYNC_BUSY_BIT = 18;
   localparam int BYTE_ORDER_BIT = 16;
   localparam int MODES_LSB = 14;
   localparam int FIFO_LSB = 8;
   localparam int PREFETCH_LSB = 0;
   localparam logic [5:0] PREFETCH_RST = 6'h01;
   // eeprom control and status fields
   localparam int EE_ADDR_LSB = 24;
   localparam int EE_DATA_LSB = 16;
   localparam int EE_ACT_BIT = 7;
   localparam int EE_READ_BIT = 6;
   // second control register fields
   localparam int TA_ON_BIT = 18;
   localparam int EE_ENABLE_BIT = 3;
   localparam logic [31:0] MISC2_RST = 32'h0000_0000;
   // strap capture waits for the synchronisers to fill
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   // master processor families selected by the mode field
   typedef enum logic [1:0] {
      MASTER_FIRST,
      MASTER_SECOND,
      MASTER_THIRD
   } master_type_t;
endpackage

/* File: tb/bridge_misc_checker.sv */
// checker: timing and field relations at the misc control block ports
// assumes a bind into bridge_misc_control_status and one clock domain
`timescale 1ns/10ps
`default_nettype none
module bridge_misc_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pci_rst_n,
   input wire logic local_reset_in_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic ee_start,
   input wire logic ee_read,
   input wire logic [7:0] ee_addr,
   input wire logic [7:0] ee_wdata,
   input wire logic local_reset_out_n,
   input wire logic [7:0] prefetch_bytes,
   input wire logic [1:0] strap_bus_modes,
   input wire logic [1:0] master_type,
   input wire logic slave_family
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // decoded accesses and write fields, named so $past sees plain signals
   wire acc = reg_wr || reg_rd;
   wire misc_wr = reg_wr && reg_addr == bridge_misc_pkg::MISC_CONTROL_STATUS_OFS;
   wire ee_wr = reg_wr && reg_addr == bridge_misc_pkg::EE_CS_OFS;
   wire [7:0] w_addr = reg_wdata[31:24];
   wire [7:0] w_data = reg_wdata[23:16];
   wire w_read = reg_wdata[6];
   wire [5:0] w_cnt = reg_wdata[5:0];
   // both reset pins quiet; the sync delay needs several such cycles
   wire quiet = pci_rst_n && local_reset_in_n;
   wire [1:0] exp_type = strap_bus_modes == 2'h3 ? 2'h2 :
      {1'b0, strap_bus_modes == 2'h2};

   a_ack_follows: assert property (acc |=> reg_ack)
      else $error("access without acknowledge");
   a_ack_cause: assert property (reg_ack |-> $past(acc))
      else $error("acknowledge without access");
   a_soft_set: assert property (quiet[*5] ##0 (misc_wr && reg_wdata[31])
      |=> !local_reset_out_n)
      else $error("soft reset write did not assert output");
   a_soft_clr: assert property (quiet[*5] ##0 (misc_wr && !reg_wdata[31])
      |=> local_reset_out_n)
      else $error("soft reset clear did not release output");
   a_local_in: assert property ((!local_reset_in_n && pci_rst_n)[*5]
      |-> local_reset_out_n)
      else $error("local reset input did not release output");
   a_pci_hold: assert property (local_reset_in_n[*5] ##0
      (!pci_rst_n && !local_reset_out_n) |=> !local_reset_out_n)
      else $error("output released during pci reset");
   a_ee_fields: assert property (ee_start |-> $past(ee_wr) && ee_addr ==
      $past(w_addr) && ee_wdata == $past(w_data) &&
      ee_read == $past(w_read))
      else $error("eeprom start without matching write");
   // the byte count is registered from the stored field, two edges late
   a_prefetch: assert property (misc_wr |-> ##2 prefetch_bytes ==
      {$past(w_cnt, 2), 2'h0})
      else $error("prefetch bytes not four times count");
   a_mode_decode: assert property ($stable(strap_bus_modes) &&
      strap_bus_modes == $past(strap_bus_modes, 2) |-> master_type ==
      exp_type && slave_family == strap_bus_modes[0])
      else $error("mode field decode wrong");
endmodule
`default_nettype wire

/* File: tb/ee_engine_model.sv */
// behavioural serial eeprom engine facing the register port
// assumes one transfer at a time, started by a one-cycle ee_start
`timescale 1ns/10ps
`default_nettype none
module ee_engine_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic ee_start,
   input wire logic ee_read,
   input wire logic [7:0] ee_addr,
   input wire logic [7:0] ee_wdata,
   output logic ee_loading,
   output logic ee_done,
   output logic [7:0] ee_rdata
);
   logic [7:0] mem_q [256]; // eeprom array, unwritten bytes unknown
   logic [5:0] cnt_q; // cycles left in boot load or transfer
   logic boot_q, busy_q, rd_q;
   logic [7:0] addr_q;
   assign ee_loading = boot_q;
   // boot load first, then transfers with a short or long latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 6'h28;
         boot_q <= 1'b1;
         busy_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         ee_done <= 1'b0;
         ee_rdata <= 8'h00;
      end else begin
         ee_done <= 1'b0;
         // byte is valid with done only; flip it so stale data never fits
         ee_rdata <= ~ee_rdata;
         if (cnt_q != 6'h00) cnt_q <= cnt_q - 6'h01;
         if (cnt_q == 6'h01) boot_q <= 1'b0;
         if (ee_start) begin
            busy_q <= 1'b1;
            rd_q <= ee_read;
            addr_q <= ee_addr;
            cnt_q <= slow ? 6'h14 : 6'h02;
            if (!ee_read) mem_q[ee_addr] <= ee_wdata;
         end else if (busy_q && cnt_q == 6'h01) begin
            busy_q <= 1'b0;
            ee_done <= 1'b1;
            if (rd_q) ee_rdata <= mem_q[addr_q];
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// top bench: straps, reset pins and register traffic for bridge_misc_control_status
// assumes the package, the checker and the eeprom model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [11:0] MC = bridge_misc_pkg::MISC_CONTROL_STATUS_OFS;
   localparam logic [11:0] EE = bridge_misc_pkg::EE_CS_OFS;
   localparam logic [11:0] M2 = bridge_misc_pkg::MISC2_OFS;
   logic clk, rst_n, pci_rst_n, burst_progress_strap, size_strap_bit;
   logic local_reset_in_n; // driven alone, never from the output
   logic ee_sda_in, id_enable_strap, reg_wr, reg_rd, reg_ack, slow;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic ee_loading, ee_done, ee_start, ee_read, local_reset_out_n;
   logic [7:0] ee_rdata, ee_addr, ee_wdata, prefetch_bytes, a, dt;
   logic [1:0] strap_bus_modes, master_type;
   logic slave_family, sync_grant_sel, sync_busy_sel, target_order_invert;
   logic dma_order_invert, slave_swap, target_swap, dma_swap;
   logic target_abort_to_error;
   logic [32:0] note_q [$]; // compare flag and expected read data
   logic [32:0] note;
   logic [5:0] cnt;
   logic [2:0] b;
   int err_count = 0;
   int n_tests = 0;
   bridge_misc_control_status i_dut (.clk, .rst_n, .pci_rst_n, .local_reset_in_n,
      .burst_progress_strap, .size_strap_bit, .ee_sda_in, .id_enable_strap,
      .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
      .ee_loading, .ee_done, .ee_rdata, .ee_start, .ee_read, .ee_addr,
      .ee_wdata, .local_reset_out_n, .prefetch_bytes, .strap_bus_modes,
      .master_type, .slave_family, .sync_grant_sel, .sync_busy_sel,
      .target_order_invert, .dma_order_invert, .slave_swap, .target_swap,
      .dma_swap, .target_abort_to_error);
   ee_engine_model i_ee (.clk, .rst_n, .slow, .ee_start, .ee_read,
      .ee_addr, .ee_wdata, .ee_loading, .ee_done, .ee_rdata);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one strobe cycle, then one cycle for the acknowledge to land
   task automatic acc(input logic wr, input logic [11:0] ad,
         input logic [31:0] d, input logic cmp, input logic [31:0] e);
      note_q.push_back({cmp, e});
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      acc(1'b1, ad, d, 1'b0, 32'h0);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      acc(1'b0, ad, 32'h0, 1'b1, e);
   endtask
   // polls the active flag; a bound that runs out ends the run
   task automatic idle();
      for (int i = 0; i < 100; i++) begin
         acc(1'b0, EE, 32'h0, 1'b0, 32'h0);
         if (reg_rdata[7] === 1'b0) return;
      end
      err_count++;
      results();
   endtask
   // each acknowledge takes the oldest note; reads are compared
   always @(posedge clk) begin
      if (reg_ack === 1'b1) begin
         note = note_q.pop_front();
         if (note[32]) chk(reg_rdata, note[31:0]);
      end
   end
   initial begin
      {rst_n, pci_rst_n, local_reset_in_n, reg_wr, reg_rd} = 5'h0C;
      {burst_progress_strap, size_strap_bit, slow} = 3'h1;
      {ee_sda_in, id_enable_strap} = 2'h3;
      {target_order_invert, dma_order_invert} = 2'h0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      void'($urandom(32'h86A0));
      @(posedge clk);
      for (int m = 0; m < 4; m++) begin
         rst_n <= 1'b0;
         pci_rst_n <= 1'b0;
         {burst_progress_strap, size_strap_bit} <= 2'(m);
         cyc(8);
         {rst_n, pci_rst_n} <= 2'h3;
         cyc(8);
         chk(32'(strap_bus_modes), 32'(m));
         chk(32'({master_type, slave_family}),
            m > 1 ? 2 * m - 2 + (m & 1) : m & 1);
         chk(32'({sync_grant_sel, sync_busy_sel}), m > 1 ? 3 : 0);
         chk({prefetch_bytes, local_reset_out_n}, 32'h9);
         rd(MC, {12'h0, m > 1, m > 1, 2'h0, 2'(m), 14'h1});
         rd(EE, 32'h0000_0080);
      end
      rd(M2, 32'h0);
      rd(12'h80C, 32'h0);
      for (int i = 0; i < 3; i++) begin
         cnt = i == 0 ? 6'h3F : (i == 1 ? 6'h00 : 6'($urandom));
         wr(MC, {26'h3, cnt});
         // byte count follows the field one edge later
         cyc(1);
         chk(32'(prefetch_bytes), 32'({cnt, 2'h0}));
         // unmapped bits read zero, strap modes stay as captured
         rd(MC, {18'h3, 8'h0, cnt});
      end
      for (int i = 0; i < 8; i++) begin
         b = 3'(i);
         {target_order_invert, dma_order_invert} <= b[1:0];
         wr(MC, {15'h0, b[2], 16'h0});
         cyc(1);
         chk(32'({slave_swap, target_swap, dma_swap}),
            32'({b[2], b[2] ^ b[1], b[2] ^ b[0]}));
      end
      rd(MC, 32'h0001_C000);
      wr(MC, 32'h0010_0000);
      cyc(1);
      chk(32'(target_abort_to_error), 32'h0);
      wr(M2, 32'h0004_0000);
      cyc(1);
      chk(32'(target_abort_to_error), 32'h1);
      rd(M2, 32'h0004_0000);
      idle();
      a = 8'($urandom);
      dt = 8'($urandom);
      wr(EE, {a, dt, 16'h0});
      rd(EE, {a, dt, 16'h0080});
      wr(EE, {~a, ~dt, 16'h0});
      rd(EE, {a, dt, 16'h0080});
      idle();
      slow <= 1'b0;
      wr(EE, {a, 24'h40});
      idle();
      rd(EE, {a, dt, 16'h0040});
      wr(MC, 32'h8000_0000);
      chk(32'(local_reset_out_n), 32'h0);
      rd(MC, 32'h8000_C000);
      wr(MC, 32'h0);
      chk(32'(local_reset_out_n), 32'h1);
      wr(MC, 32'h8000_0000);
      local_reset_in_n <= 1'b0;
      cyc(5);
      chk(32'(local_reset_out_n), 32'h1);
      local_reset_in_n <= 1'b1;
      cyc(4);
      rd(MC, 32'h0000_C000);
      wr(MC, 32'h8000_0000);
      {ee_sda_in, id_enable_strap, pci_rst_n} <= 3'h0;
      cyc(6);
      chk(32'(local_reset_out_n), 32'h0);
      rd(MC, 32'h0000_C000);
      pci_rst_n <= 1'b1;
      cyc(5);
      chk(32'(local_reset_out_n), 32'h1);
      wr(EE, {a, dt, 16'h0});
      rd(EE, 32'h0);
      wr(M2, 32'h0004_0008);
      // fields were cleared by the pci reset
      rd(EE, 32'h0);
      wr(EE, {a, dt, 16'h0});
      rd(EE, {a, dt, 16'h0080});
      idle();
      results();
   end
endmodule
bind bridge_misc_control_status bridge_misc_checker i_chk (.clk, .rst_n, .pci_rst_n,
   .local_reset_in_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_ack,
   .ee_start, .ee_read, .ee_addr, .ee_wdata, .local_reset_out_n,
   .prefetch_bytes, .strap_bus_modes, .master_type, .slave_family);
`default_nettype wire
